// *** rtl/ifd_decoder.sv ***
// Instruction format decoder: classifies fetched words, generates shared
// operand values and the next address. Fetch word valid is sampled each
// cycle; register file read data arrives combinationally for reg_a/reg_b.
`timescale 1ns/10ps
`default_nettype none
module ifd_decoder
    import ifd_pkg::*;
#(
    parameter int XLEN = IFD_XLEN
) (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire ifd_fetch_type fetch_i, // Fetched word and address
    input wire logic branch_taken_i, // Branch resolved taken
    input wire logic [31:0] branch_target_i, // Branch target
    input wire logic [31:0] reg_a_data_i, // Register file read port A
    input wire logic [31:0] reg_b_data_i, // Register file read port B
    input wire logic [31:0] reg_s_data_i, // Register file read port S
    output logic [4:0] reg_a_sel_o, // Read select A
    output logic [4:0] reg_b_sel_o, // Read select B
    output logic [4:0] reg_s_sel_o, // Read select S
    output ifd_decode_type dec_o, // Registered decode result
    output logic illegal_exc_o, // Illegal instruction exception pulse
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    output logic irq_o // Level interrupt
);
    // Elaboration check: the datapath is fixed at 32 bits
    if (XLEN != IFD_XLEN) begin : g_bad_xlen
        $error("ifd_decoder supports only 32-bit words");
    end

    logic [31:0] w;
    logic [5:0] opc;
    logic [9:0] xo;
    logic [4:0] fa;
    logic [4:0] fb;
    logic [4:0] ft;
    logic [4:0] mb;
    logic [4:0] me;
    logic fixed_bad;
    logic rsvd_bad;
    logic known;
    logic impl;
    logic has_oe;
    logic has_rc;
    logic ra_zero_form;
    logic cmp_form;
    logic [31:0] imm_ext_d;
    logic [31:0] opa_d;
    logic [31:0] rot_d;
    logic [31:0] mask_d;
    logic [31:0] ea_d;
    logic [31:0] nia_d;
    logic [3:0] cond_d;
    ifd_class_type cls_d;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic [0:0] ctrl_q;
    logic [31:0] last_q;
    logic [31:0] count_q;
    logic [31:0] cia_q;
    logic wb_req;

    assign w = fetch_i.word;
    assign opc = w[IFD_OPC_HI:IFD_OPC_LO];
    assign xo = w[IFD_XO_LO +: 10];
    assign fa = w[IFD_RA_LO +: 5];
    assign fb = w[IFD_RB_LO +: 5];
    assign ft = w[IFD_RT_LO +: 5];
    assign mb = w[IFD_MB_LO +: 5];
    assign me = w[IFD_ME_LO +: 5];
    assign reg_a_sel_o = fa;
    assign reg_b_sel_o = fb;
    assign reg_s_sel_o = ft;

    // Format checks: fixed fields and reserved fields
    always_comb begin
        known = 1'b1;
        impl = 1'b0;
        has_oe = 1'b0;
        has_rc = 1'b0;
        rsvd_bad = 1'b0;
        ra_zero_form = 1'b0;
        cmp_form = 1'b0;
        if (opc == IFD_OP_ADDI || opc == IFD_OP_ADDIS) begin
            ra_zero_form = 1'b1;
        end else if (opc == IFD_OP_ADDIC_R) begin
            has_rc = 1'b1;
        end else if (opc == IFD_OP_RLWINM) begin
            has_rc = w[IFD_RC_BIT];
        end else if (opc == IFD_OP_B || opc == IFD_OP_BC) begin
            known = 1'b1;
        end else if (opc == IFD_OP_XL) begin
            known = (xo == IFD_XO_RFCI);
            impl = known;
            rsvd_bad = |w[25:11] | w[0];
        end else if (opc == IFD_OP_MAC) begin
            impl = 1'b1;
            has_oe = w[IFD_OE_BIT] & ~w[8]; // multiplies have no o form
            has_rc = w[IFD_RC_BIT];
        end else if (opc == IFD_OP_X) begin
            has_rc = w[IFD_RC_BIT];
            if (w[9:1] == 9'h10a || w[9:1] == 9'h00a || w[9:1] == 9'h08a) begin
                has_oe = w[IFD_OE_BIT];
            end else if (xo == IFD_XO_CMP) begin
                cmp_form = 1'b1;
                rsvd_bad = w[22] | w[0];
                has_rc = 1'b0;
            end else if (xo == IFD_XO_MFDCR || xo == IFD_XO_MTDCR) begin
                impl = 1'b1;
                rsvd_bad = w[0];
                has_rc = 1'b0;
            end else if (xo == IFD_XO_WRTEE || xo == IFD_XO_WRTEEI
                         || xo == IFD_XO_TLBRE || xo == IFD_XO_TLBWE) begin
                impl = 1'b1;
                rsvd_bad = w[0];
                has_rc = 1'b0;
            end else if (xo == IFD_XO_TLBSX) begin
                impl = 1'b1;
                ra_zero_form = 1'b1;
            end else if (xo == IFD_XO_DCCCI || xo == IFD_XO_ICCCI
                         || xo == IFD_XO_DCREAD || xo == IFD_XO_ICREAD) begin
                impl = 1'b1;
                ra_zero_form = 1'b1;
                rsvd_bad = w[0] | ((xo == IFD_XO_DCCCI || xo == IFD_XO_ICCCI)
                           && (|ft));
                has_rc = 1'b0;
            end else begin
                known = 1'b0;
            end
        end else begin
            known = 1'b0;
        end
        fixed_bad = ~known;
    end

    // Classification ahead of any architected update
    always_comb begin
        if (fixed_bad) begin
            cls_d = IFD_CLS_ILLEGAL;
        end else if (rsvd_bad) begin
            cls_d = IFD_CLS_INVALID;
        end else begin
            cls_d = IFD_CLS_LEGAL;
        end
    end

    // Shared operand semantics
    always_comb begin
        imm_ext_d = {{16{w[15]}}, w[15:0]};
        if (opc == IFD_OP_ADDIS) begin
            imm_ext_d = {w[15:0], 16'h0000};
        end
        opa_d = (ra_zero_form && fa == 5'd0) ? 32'h0000_0000 : reg_a_data_i;
        rot_d = (reg_s_data_i << fb) | (reg_s_data_i >> (6'd32 - {1'b0, fb}));
        for (int i = 0; i < 32; i++) begin
            // Big-endian position p maps to index 31-p
            if (mb <= me) begin
                mask_d[31 - i] = (5'(i) >= mb) && (5'(i) <= me);
            end else begin
                mask_d[31 - i] = (5'(i) >= mb) || (5'(i) <= me);
            end
        end
        if (opc == IFD_OP_X) begin
            ea_d = opa_d + reg_b_data_i;
        end else begin
            ea_d = opa_d + imm_ext_d;
        end
        nia_d = branch_taken_i ? branch_target_i : cia_q + IFD_INSTR_STEP;
        if ($signed(reg_a_data_i) < $signed(reg_b_data_i)) begin
            cond_d = 4'b1000;
        end else if ($signed(reg_a_data_i) > $signed(reg_b_data_i)) begin
            cond_d = 4'b0100;
        end else begin
            cond_d = 4'b0010;
        end
    end

    // Current address tracks the fetched word, low bits forced aligned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cia_q <= 32'h0000_0000;
        end else if (fetch_i.valid) begin
            cia_q <= {fetch_i.addr[31:2], 2'b00};
        end
    end

    // Registered decode result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_o <= '0;
            dec_o.cls <= IFD_CLS_LEGAL;
            illegal_exc_o <= 1'b0;
        end else begin
            dec_o.valid <= fetch_i.valid;
            dec_o.cls <= cls_d;
            dec_o.opcode <= opc;
            dec_o.ext_opcode <= xo;
            dec_o.impl_specific <= impl;
            dec_o.overflow_update <= has_oe & ~fixed_bad;
            dec_o.record_update <= has_rc & ~fixed_bad;
            dec_o.reg_a <= fa;
            dec_o.reg_b <= fb;
            dec_o.reg_t <= ft;
            dec_o.operand_a <= opa_d;
            dec_o.imm_ext <= imm_ext_d;
            dec_o.rotated <= rot_d;
            dec_o.mask <= mask_d;
            dec_o.eff_addr <= ea_d;
            dec_o.next_addr <= nia_d;
            dec_o.cond <= cmp_form ? cond_d : 4'h0;
            illegal_exc_o <= fetch_i.valid & fixed_bad & ctrl_q[0];
        end
    end

    // Event status, set wins over write-one-to-clear
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= IFD_STATUS_RST;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wb_req && wb_we_i && wb_adr_i == IFD_REG_STATUS && wb_sel_i[0]
                    && wb_dat_i[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
            if (fetch_i.valid && fixed_bad) begin
                status_q[IFD_EVT_ILLEGAL] <= 1'b1;
            end
            if (fetch_i.valid && !fixed_bad && rsvd_bad) begin
                status_q[IFD_EVT_INVALID] <= 1'b1;
            end
            if (fetch_i.valid && branch_taken_i) begin
                status_q[2] <= 1'b1;
            end
        end
    end

    // Last illegal word and legal word count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_q <= 32'h0000_0000;
            count_q <= 32'h0000_0000;
        end else begin
            if (fetch_i.valid && fixed_bad) begin
                last_q <= w;
            end
            if (wb_req && wb_we_i && wb_adr_i == IFD_REG_COUNT) begin
                count_q <= 32'h0000_0000;
            end else if (fetch_i.valid && cls_d == IFD_CLS_LEGAL) begin
                count_q <= count_q + 32'h0000_0001;
            end
        end
    end

    // Wishbone slave: one ack per request, registered one cycle after it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= IFD_MASK_RST;
            ctrl_q <= IFD_CTRL_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            irq_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            irq_o <= |(status_q & mask_q);
            if (wb_req && wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == IFD_REG_MASK) begin
                    mask_q <= wb_dat_i[2:0];
                end else if (wb_adr_i == IFD_REG_CTRL) begin
                    ctrl_q <= wb_dat_i[0:0];
                end
            end
            if (wb_req && !wb_we_i) begin
                if (wb_adr_i == IFD_REG_STATUS) begin
                    wb_dat_o <= {29'h0, status_q};
                end else if (wb_adr_i == IFD_REG_MASK) begin
                    wb_dat_o <= {29'h0, mask_q};
                end else if (wb_adr_i == IFD_REG_LAST) begin
                    wb_dat_o <= last_q;
                end else if (wb_adr_i == IFD_REG_COUNT) begin
                    wb_dat_o <= count_q;
                end else if (wb_adr_i == IFD_REG_CTRL) begin
                    wb_dat_o <= {31'h0, ctrl_q};
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

    chk_illegal_raise: assert property (@(posedge clk_i) disable iff (rst_i)
        fetch_i.valid && fixed_bad && ctrl_q[0] |=> illegal_exc_o && dec_o.cls == IFD_CLS_ILLEGAL)
        else $error("illegal word did not raise exception");
    chk_invalid_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        fetch_i.valid && !fixed_bad && rsvd_bad |=> !illegal_exc_o && dec_o.cls == IFD_CLS_INVALID)
        else $error("invalid form misclassified");
    chk_next_seq: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && !branch_taken_i |=> dec_o.next_addr == $past(cia_q) + IFD_INSTR_STEP)
        else $error("sequential next address wrong");
    chk_next_branch: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && branch_taken_i |=> dec_o.next_addr == $past(branch_target_i))
        else $error("branch target not taken");
    chk_ra_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ra_zero_form && fa == 5'd0 |=> dec_o.operand_a == 32'h0000_0000)
        else $error("ra-or-zero not zero");
    chk_sign_ext: assert property (@(posedge clk_i) disable iff (rst_i)
        opc != IFD_OP_ADDIS |=> dec_o.imm_ext[31:16] == {16{dec_o.imm_ext[15]}})
        else $error("sign extension wrong");
    chk_mask_ends: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i |=> dec_o.mask[31 - $past(mb)] && dec_o.mask[31 - $past(me)])
        else $error("mask misses its ends");
    chk_record_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        opc == IFD_OP_ADDIC_R |=> dec_o.record_update)
        else $error("record form not flagged");
    chk_align_cia: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && fetch_i.valid |=> cia_q == ($past(fetch_i.addr) & 32'hffff_fffc))
        else $error("current address not aligned");
endmodule : ifd_decoder
`default_nettype wire

// *** pkg/ifd_pkg.sv ***
// Package for the instruction format decoder: field positions, opcodes,
// register map of the Wishbone slave and the packed carriers.
// Assumes big-endian bit numbering of the instruction word (bit 0 is MSB).
package ifd_pkg;
    localparam int IFD_XLEN = 32;
    localparam int IFD_INSTR_BYTES = 4;
    localparam logic [31:0] IFD_INSTR_STEP = 32'h0000_0004;
    localparam int IFD_NREGS = 32;
    // Field positions in little-endian index (31 - printed bit)
    localparam int IFD_OPC_HI = 31;
    localparam int IFD_OPC_LO = 26;
    localparam int IFD_RT_LO = 21;
    localparam int IFD_RA_LO = 16;
    localparam int IFD_RB_LO = 11;
    localparam int IFD_MB_LO = 6;
    localparam int IFD_ME_LO = 1;
    localparam int IFD_XO_LO = 1;
    localparam int IFD_OE_BIT = 10;
    localparam int IFD_RC_BIT = 0;
    // Primary opcodes
    localparam logic [5:0] IFD_OP_MAC = 6'h04;
    localparam logic [5:0] IFD_OP_ADDIC_R = 6'h0d;
    localparam logic [5:0] IFD_OP_ADDI = 6'h0e;
    localparam logic [5:0] IFD_OP_ADDIS = 6'h0f;
    localparam logic [5:0] IFD_OP_BC = 6'h10;
    localparam logic [5:0] IFD_OP_B = 6'h12;
    localparam logic [5:0] IFD_OP_XL = 6'h13;
    localparam logic [5:0] IFD_OP_RLWINM = 6'h15;
    localparam logic [5:0] IFD_OP_X = 6'h1f;
    // Extended opcodes, 10-bit field
    localparam logic [9:0] IFD_XO_RFCI = 10'h033;
    localparam logic [9:0] IFD_XO_MFDCR = 10'h143;
    localparam logic [9:0] IFD_XO_MTDCR = 10'h1c3;
    localparam logic [9:0] IFD_XO_WRTEE = 10'h083;
    localparam logic [9:0] IFD_XO_WRTEEI = 10'h0a3;
    localparam logic [9:0] IFD_XO_DCCCI = 10'h1c6;
    localparam logic [9:0] IFD_XO_DCREAD = 10'h1e6;
    localparam logic [9:0] IFD_XO_ICCCI = 10'h3c6;
    localparam logic [9:0] IFD_XO_ICREAD = 10'h3e6;
    localparam logic [9:0] IFD_XO_TLBRE = 10'h3b2;
    localparam logic [9:0] IFD_XO_TLBWE = 10'h3d2;
    localparam logic [9:0] IFD_XO_TLBSX = 10'h392;
    localparam logic [9:0] IFD_XO_CMP = 10'h000;
    // Wishbone register offsets (byte addresses)
    localparam logic [7:0] IFD_REG_STATUS = 8'h00;
    localparam logic [7:0] IFD_REG_MASK = 8'h04;
    localparam logic [7:0] IFD_REG_LAST = 8'h08;
    localparam logic [7:0] IFD_REG_COUNT = 8'h0c;
    localparam logic [7:0] IFD_REG_CTRL = 8'h10;
    localparam logic [1:0] IFD_EVT_ILLEGAL = 2'd0;
    localparam logic [1:0] IFD_EVT_INVALID = 2'd1;
    localparam logic [2:0] IFD_STATUS_RST = 3'h0;
    localparam logic [2:0] IFD_MASK_RST = 3'h0;
    localparam logic [0:0] IFD_CTRL_RST = 1'h1;

    typedef enum logic [2:0] {
        IFD_CLS_LEGAL = 3'b001,
        IFD_CLS_INVALID = 3'b010,
        IFD_CLS_ILLEGAL = 3'b100
    } ifd_class_type;

    typedef struct packed {
        logic valid;
        logic [31:0] word;
        logic [31:0] addr;
    } ifd_fetch_type;

    typedef struct packed {
        logic valid;
        ifd_class_type cls;
        logic [5:0] opcode;
        logic [9:0] ext_opcode;
        logic impl_specific;
        logic overflow_update;
        logic record_update;
        logic [4:0] reg_a;
        logic [4:0] reg_b;
        logic [4:0] reg_t;
        logic [31:0] operand_a;
        logic [31:0] imm_ext;
        logic [31:0] rotated;
        logic [31:0] mask;
        logic [31:0] eff_addr;
        logic [31:0] next_addr;
        logic [3:0] cond;
    } ifd_decode_type;
endpackage : ifd_pkg

// *** tb/ifd_regfile_model.sv ***
// Register file model on the far side of the decoder's operand path.
// Assumes the decoder expects read data combinationally from its selects.
`timescale 1ns/10ps
`default_nettype none
module ifd_regfile_model (
    input wire logic [4:0] sel_a_i, // Read select A
    input wire logic [4:0] sel_b_i, // Read select B
    input wire logic [4:0] sel_s_i, // Read select S
    output logic [31:0] dat_a_o, // Read data A
    output logic [31:0] dat_b_o, // Read data B
    output logic [31:0] dat_s_o // Read data S
);
    logic [31:0] general_register [32];

    // Upper half of the file holds negative values for signed compares
    initial begin
        for (int i = 0; i < 32; i++) begin
            general_register[i] = {{16{i[4]}}, 3'h0, 5'(i), 8'ha5};
        end
    end

    assign dat_a_o = general_register[sel_a_i];
    assign dat_b_o = general_register[sel_b_i];
    assign dat_s_o = general_register[sel_s_i];
endmodule : ifd_regfile_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the instruction format decoder.
// Assumes the register file model answers the read selects combinationally.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ifd_pkg::*;
    logic clk_i, rst_i, taken, cyc, stb, we, exc, exc1, ack, irq;
    ifd_fetch_type fetch;
    ifd_decode_type dec, d;
    logic [31:0] target, wdat, rda, rdb, rds, rdat, wb_rd, w;
    logic [4:0] sa, sb, ss;
    logic [7:0] adr;
    logic [3:0] sel;
    int mismatches, check_count, cycles;

    ifd_regfile_model i_regs (.sel_a_i(sa), .sel_b_i(sb), .sel_s_i(ss),
        .dat_a_o(rda), .dat_b_o(rdb), .dat_s_o(rds));
    ifd_decoder i_dut (.clk_i(clk_i), .rst_i(rst_i), .fetch_i(fetch),
        .branch_taken_i(taken), .branch_target_i(target), .reg_a_data_i(rda),
        .reg_b_data_i(rdb), .reg_s_data_i(rds), .reg_a_sel_o(sa), .reg_b_sel_o(sb),
        .reg_s_sel_o(ss), .dec_o(dec), .illegal_exc_o(exc), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));

    function automatic logic [31:0] gv(input logic [4:0] i);
        return {{16{i[4]}}, 3'h0, i, 8'ha5};
    endfunction : gv

    function automatic logic [31:0] mk(input int mb, input int me);
        logic [31:0] m;
        for (int p = 0; p < 32; p++) begin
            m[31-p] = (mb <= me) ? (p >= mb && p <= me) : (p >= mb || p <= me);
        end
        return m;
    endfunction : mk

    function automatic logic [31:0] rl(input logic [31:0] v, input int n);
        logic [31:0] r;
        for (int p = 0; p < 32; p++) begin
            r[(p + n) % 32] = v[p];
        end
        return r;
    endfunction : rl

    function automatic logic [31:0] xw(input logic [5:0] op, input logic [4:0] t, a, b,
        input logic [9:0] xo, input logic rc);
        return {op, t, a, b, xo, rc};
    endfunction : xw

    task automatic check(input string name, input logic [31:0] exp, got);
        check_count++;
        if (exp !== got) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Classic single cycle; waits for ack, the cycle timeout cuts a hang
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= v;
        do @(posedge clk_i); while (ack !== 1'b1);
        wb_rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        wb(1'b0, a, 32'h0);
        check(name, exp, wb_rd);
    endtask : rd

    // Word is presented for two edges; dec_o is taken after the second
    task automatic drive(input logic [31:0] wd, input logic [31:0] a, input logic tk);
        @(posedge clk_i);
        fetch <= '{valid: 1'b1, word: wd, addr: a};
        taken <= tk;
        @(posedge clk_i);
        #1;
        exc1 = exc;
        check("sels", {17'h0, wd[20:16], wd[15:11], wd[25:21]}, {17'h0, sa, sb, ss});
        @(posedge clk_i);
        fetch.valid <= 1'b0;
        taken <= 1'b0;
        #1;
        d = dec;
    endtask : drive

    task automatic t_regs();
        rd(IFD_REG_STATUS, 32'h0, "status");
        rd(IFD_REG_MASK, 32'h0, "mask");
        rd(IFD_REG_LAST, 32'h0, "last");
        rd(IFD_REG_CTRL, 32'h1, "ctrl");
        wb(1'b1, 8'h14, 32'hffff_ffff);
        rd(8'h14, 32'h0, "unmapped");
        wb(1'b1, IFD_REG_MASK, 32'h0000_0001);
        rd(IFD_REG_MASK, 32'h1, "mask");
        sel <= 4'he;
        wb(1'b1, IFD_REG_MASK, 32'h0000_0006);
        sel <= 4'hf;
        rd(IFD_REG_MASK, 32'h1, "mask sel");
        $display("test regs done");
    endtask : t_regs

    task automatic t_class();
        wb(1'b1, IFD_REG_COUNT, 32'h0);
        drive(xw(IFD_OP_ADDI, 5'd1, 5'd2, 5'd3, 10'h155, 1'b1), 32'h100, 1'b0);
        check("cls", {29'h0, IFD_CLS_LEGAL}, {29'h0, d.cls});
        check("exc", 32'h0, {31'h0, exc1});
        rd(IFD_REG_COUNT, 32'h2, "count");
        w = xw(6'h00, 5'd7, 5'd1, 5'd2, 10'h2aa, 1'b1);
        drive(w, 32'h104, 1'b0);
        check("cls", {29'h0, IFD_CLS_ILLEGAL}, {29'h0, d.cls});
        check("exc", 32'h1, {31'h0, exc1});
        check("opcode", 32'h0, {26'h0, d.opcode});
        rd(IFD_REG_STATUS, 32'h1, "status");
        rd(IFD_REG_LAST, w, "last");
        check("irq", 32'h1, {31'h0, irq});
        wb(1'b1, IFD_REG_STATUS, 32'h1);
        rd(IFD_REG_STATUS, 32'h0, "status");
        check("irq", 32'h0, {31'h0, irq});
        drive(xw(IFD_OP_X, 5'd0, 5'd1, 5'd2, IFD_XO_CMP, 1'b1), 32'h108, 1'b0);
        check("cls", {29'h0, IFD_CLS_INVALID}, {29'h0, d.cls});
        check("exc", 32'h0, {31'h0, exc1});
        rd(IFD_REG_STATUS, 32'h2, "status");
        check("irq", 32'h0, {31'h0, irq});
        wb(1'b1, IFD_REG_CTRL, 32'h0);
        drive(w, 32'h10c, 1'b0);
        check("exc", 32'h0, {31'h0, exc1});
        check("cls", {29'h0, IFD_CLS_ILLEGAL}, {29'h0, d.cls});
        wb(1'b1, IFD_REG_CTRL, 32'h1);
        wb(1'b1, IFD_REG_STATUS, 32'h7);
        $display("test class done");
    endtask : t_class

    task automatic t_ops();
        drive(xw(IFD_OP_ADDI, 5'd4, 5'd0, 5'h10, 10'h001, 1'b1), 32'h200, 1'b0);
        check("operand_a", 32'h0, d.operand_a);
        check("imm_ext", 32'hffff_8003, d.imm_ext);
        check("reg_t", 32'h4, {27'h0, d.reg_t});
        check("reg_ab", 32'h0000_0010, {22'h0, d.reg_a, d.reg_b});
        check("valid", 32'h1, {31'h0, d.valid});
        check("next_addr", 32'h0000_0204, d.next_addr);
        drive(xw(IFD_OP_ADDI, 5'd31, 5'd17, 5'h0f, 10'h3ff, 1'b0), 32'hffff_fff8, 1'b0);
        check("operand_a", gv(5'd17), d.operand_a);
        check("imm_ext", 32'h0000_7ffe, d.imm_ext);
        check("eff_addr", gv(5'd17) + 32'h0000_7ffe, d.eff_addr);
        check("next_addr", 32'hffff_fffc, d.next_addr);
        drive(xw(IFD_OP_ADDIS, 5'd2, 5'd0, 5'h12, 10'h000, 1'b1), 32'h0000_0702, 1'b0);
        check("operand_a", 32'h0, d.operand_a);
        check("eff_addr", 32'h9001_0000, d.eff_addr);
        check("next_addr", 32'h0000_0704, d.next_addr);
        drive(xw(IFD_OP_B, 5'd0, 5'd0, 5'd0, 10'h0, 1'b0), 32'h300, 1'b1);
        check("next_addr", target, d.next_addr);
        $display("test operands done");
    endtask : t_ops

    task automatic t_rot();
        logic [4:0] rs[3] = '{5'd5, 5'd20, 5'd31};
        logic [4:0] sh[3] = '{5'd0, 5'd31, 5'd7};
        logic [4:0] mb[3] = '{5'd0, 5'd30, 5'd5};
        logic [4:0] me[3] = '{5'd31, 5'd1, 5'd5};
        logic [31:0] v;
        for (int k = 0; k < 3; k++) begin
            v = gv(rs[k]);
            drive(xw(IFD_OP_RLWINM, rs[k], 5'd0, sh[k], {mb[k], me[k]}, k[0]), 32'h400, 1'b0);
            check("rotated", rl(v, sh[k]), d.rotated);
            check("mask", mk(mb[k], me[k]), d.mask);
            check("record", {31'h0, k[0]}, {31'h0, d.record_update});
        end
        $display("test rotate done");
    endtask : t_rot

    task automatic t_flags();
        logic [9:0] xo[12] = '{IFD_XO_RFCI, IFD_XO_MFDCR, IFD_XO_MTDCR, IFD_XO_WRTEE,
            IFD_XO_WRTEEI, IFD_XO_DCCCI, IFD_XO_DCREAD, IFD_XO_ICCCI, IFD_XO_ICREAD,
            IFD_XO_TLBRE, IFD_XO_TLBWE, IFD_XO_TLBSX};
        drive(xw(IFD_OP_ADDIC_R, 5'd1, 5'd2, 5'd0, 10'h0, 1'b0), 32'h500, 1'b0);
        check("record", 32'h1, {31'h0, d.record_update});
        check("overflow", 32'h0, {31'h0, d.overflow_update});
        drive(xw(IFD_OP_X, 5'd1, 5'd2, 5'd3, {1'b1, 9'h10a}, 1'b1), 32'h500, 1'b0);
        check("overflow", 32'h1, {31'h0, d.overflow_update});
        check("record", 32'h1, {31'h0, d.record_update});
        // Bit 8 of the word selects a multiply, which has no overflow form
        for (int k = 0; k < 4; k++) begin
            drive(xw(IFD_OP_MAC, 5'd1, 5'd2, 5'd3, {k[0], 1'b0, k[1], 7'd44}, 1'b0), 32'h504,
                1'b0);
            check("overflow", {31'h0, k[0] & ~k[1]}, {31'h0, d.overflow_update});
            check("impl", 32'h1, {31'h0, d.impl_specific});
        end
        for (int k = 0; k < 12; k++) begin
            drive(xw((k == 0) ? IFD_OP_XL : IFD_OP_X, 5'd0, 5'd0, 5'd0, xo[k], 1'b0), 32'h508,
                1'b0);
            check("impl", 32'h1, {31'h0, d.impl_specific});
            check("ext_opcode", {22'h0, xo[k]}, {22'h0, d.ext_opcode});
        end
        $display("test flags done");
    endtask : t_flags

    task automatic t_cond();
        logic [4:0] ra[3] = '{5'd17, 5'd3, 5'd5};
        logic [4:0] rb[3] = '{5'd3, 5'd17, 5'd5};
        logic [3:0] c[3] = '{4'b1000, 4'b0100, 4'b0010};
        for (int k = 0; k < 3; k++) begin
            drive(xw(IFD_OP_X, 5'd0, ra[k], rb[k], IFD_XO_CMP, 1'b0), 32'h600, 1'b0);
            check("cond", {28'h0, c[k]}, {28'h0, d.cond});
        end
        $display("test compare done");
    endtask : t_cond

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        rst_i = 1'b1;
        taken = 1'b0;
        target = 32'h1234_5678;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0;
        fetch = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_class();
        t_ops();
        t_rot();
        t_flags();
        t_cond();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
